// ---- hdl/fot_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
module fot_divider #(
    parameter int WIDTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] dividend,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  busy,
    output logic                  done,
    output logic      [WIDTH-1:0] quotient
);
    initial begin
        if (WIDTH < 2 || WIDTH > 255) $error("divider width out of range");
    end
    logic [WIDTH-1:0]   rem_ff;
    logic [WIDTH-1:0]   quo_ff;
    logic [WIDTH-1:0]   dvs_ff;
    logic [7:0]         cnt_ff;
    logic               done_ff;
    wire  [WIDTH:0]     trial = {rem_ff, quo_ff[WIDTH-1]};
    wire                fits  = trial >= {1'b0, dvs_ff};
    wire  [WIDTH:0]     diff  = trial - {1'b0, dvs_ff};
    // ==================================================
    // Restoring division, one quotient bit per cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rem_ff  <= '0;
            quo_ff  <= '0;
            dvs_ff  <= '0;
            cnt_ff  <= 8'h00;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (start && cnt_ff == 8'h00) begin
                rem_ff <= '0;
                quo_ff <= dividend;
                dvs_ff <= divisor;
                cnt_ff <= 8'(WIDTH);
            end else if (cnt_ff != 8'h00) begin
                rem_ff  <= fits ? diff[WIDTH-1:0] : trial[WIDTH-1:0];
                quo_ff  <= {quo_ff[WIDTH-2:0], fits};
                cnt_ff  <= cnt_ff - 8'h01;
                done_ff <= cnt_ff == 8'h01;
            end
        end
    end
    assign busy     = cnt_ff != 8'h00;
    assign done     = done_ff;
    assign quotient = quo_ff;
endmodule : fot_divider
`default_nettype wire

// ---- hdl/fot_index_rom.sv ----
`timescale 1ns/100ps
`default_nettype none
module fot_index_rom (
    input  wire logic [3:0]  index,
    output logic      [31:0] k_const,
    output logic      [7:0]  dac_code
);
    `include "fot_consts.svh"
    // ==================================================
    // Per-index division constants.
    always_comb begin
        unique case (index)
            4'h0:    k_const = 32'd45407;
            4'h1:    k_const = 32'd60543;
            4'h2:    k_const = 32'd75678;
            4'h3:    k_const = 32'd90814;
            4'h4:    k_const = 32'd105949;
            4'h5:    k_const = 32'd121085;
            4'h6:    k_const = 32'd136221;
            4'h7:    k_const = 32'd151356;
            4'h8:    k_const = 32'd166492;
            4'h9:    k_const = 32'd181628;
            default: k_const = 32'd196763;
        endcase
    end
    assign dac_code = `DAC_BASE + {4'h0, index};
endmodule : fot_index_rom
`default_nettype wire

// ---- hdl/fot_param_calc.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fot_consts.svh"
module fot_param_calc
    import fot_pkg::*;
#(
    parameter int CATH_DELAY_CYC = `CATH_DELAY_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic [3:0]           current_index_command,
    input  wire logic [9:0]           led_supply_voltage,
    input  wire logic [9:0]           led_cathode_voltage,
    input  wire logic                 sample_valid,
    input  wire logic                 dimming_on,
    input  wire logic                 sm_in_hold,
    input  wire logic                 sm_in_off_state,
    output fot_pkg::shadow_s          shadow,
    output logic                      shadow_load,
    output logic                      calc_busy
);
    import fot_pkg::*;
    initial begin
        if (CATH_DELAY_CYC < 1 || CATH_DELAY_CYC > 65536)
            $error("cathode delay does not fit the 16-bit counter");
    end
    typedef enum logic [2:0] {ST_IDLE, ST_DIV_OFF, ST_DIV_ON, ST_SPLIT, ST_APPLY} calc_e;
    calc_e            state_ff;
    calc_e            nxt_state;
    // ==================================================
    // Input synchronisers for the converter results and pins.
    logic [9:0]  sup_m_ff, sup_ff, cat_m_ff, cat_ff;
    logic [3:0]  idx_m_ff, idx_ff;
    logic        val_m_ff, val_ff, dim_m_ff, dim_ff;
    logic        hold_m_ff, hold_ff, off_m_ff, off_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {sup_m_ff, sup_ff, cat_m_ff, cat_ff} <= '0;
            {idx_m_ff, idx_ff, val_m_ff, val_ff} <= '0;
            {dim_m_ff, dim_ff, hold_m_ff, hold_ff, off_m_ff, off_ff} <= '0;
        end else if (ce) begin
            sup_m_ff  <= led_supply_voltage;
            sup_ff    <= sup_m_ff;
            cat_m_ff  <= led_cathode_voltage;
            cat_ff    <= cat_m_ff;
            idx_m_ff  <= current_index_command;
            idx_ff    <= idx_m_ff;
            val_m_ff  <= sample_valid;
            val_ff    <= val_m_ff;
            dim_m_ff  <= dimming_on;
            dim_ff    <= dim_m_ff;
            hold_m_ff <= sm_in_hold;
            hold_ff   <= hold_m_ff;
            off_m_ff  <= sm_in_off_state;
            off_ff    <= off_m_ff;
        end
    end
    // ==================================================
    // Index clamp, constant lookup and sample arithmetic.
    wire  [3:0]  idx_clamped = (idx_ff > `INDEX_MAX) ? `INDEX_MAX : idx_ff;
    logic [31:0] k_const;
    logic [7:0]  dac_code;
    fot_index_rom u_rom (
        .index    (idx_clamped),
        .k_const  (k_const),
        .dac_code (dac_code)
    );
    wire  [9:0]  drop_raw  = (sup_ff > cat_ff) ? sup_ff - cat_ff : 10'h000;
    wire  [31:0] k_on_max  = 32'((k_const * `ON_MAX_NUM) / `ON_MAX_DEN);
    // ==================================================
    // Cathode capture 100 us after each dimming on edge.
    logic [15:0] dly_cnt_ff;
    logic        dly_run_ff, dim_d_ff;
    logic [9:0]  drop_ff, cath_ff, drop_used_ff;
    logic [3:0]  idx_used_ff;
    logic        cath_new_ff;
    wire         dim_rise  = dim_ff & ~dim_d_ff;
    wire         cath_take = dly_run_ff && dly_cnt_ff == 16'(CATH_DELAY_CYC - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dly_cnt_ff <= 16'h0000;
            dly_run_ff <= 1'b0;
            dim_d_ff   <= 1'b0;
            drop_ff    <= 10'h000;
            cath_ff    <= 10'h000;
        end else if (ce) begin
            dim_d_ff <= dim_ff;
            if (dim_rise) begin
                dly_run_ff <= 1'b1;
                dly_cnt_ff <= 16'h0000;
            end else if (cath_take) begin
                dly_run_ff <= 1'b0;
                cath_ff    <= cat_ff;
            end else if (dly_run_ff) begin
                dly_cnt_ff <= dly_cnt_ff + 16'h0001;
            end
            if (val_ff)
                drop_ff <= drop_raw;
        end
    end
    // ==================================================
    // Division sequencer.
    wire         need_update = (drop_ff != drop_used_ff) || (idx_clamped != idx_used_ff)
                               || cath_new_ff;
    wire         zero_sample = (drop_ff == 10'h000) || (cath_ff == 10'h000);
    wire         apply_ok    = hold_ff || off_ff;
    logic        div_start;
    logic        div_busy, div_done;
    logic [31:0] div_q, div_a, div_b;
    fot_divider #(.WIDTH(32)) u_div (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .start    (div_start),
        .dividend (div_a),
        .divisor  (div_b),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_q)
    );
    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v > 32'(`TIMER_MAX)) ? `TIMER_MAX : v[15:0];
    endfunction : sat16
    logic [15:0] off_cnt_ff, on_max_ff;
    shadow_s     shadow_ff;
    logic        load_ff;
    wire  [31:0] fault_prod = 32'(on_max_ff) * `FAULT_PCT;
    wire  [15:0] fault_cnt  = 16'(fault_prod / 100);
    assign div_start = (state_ff == ST_DIV_OFF || state_ff == ST_DIV_ON) && !div_busy && !div_done;
    assign div_a     = (state_ff == ST_DIV_ON) ? k_on_max : k_const;
    assign div_b     = (state_ff == ST_DIV_ON) ? {22'h0, cath_ff} : {22'h0, drop_ff};
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:    if (need_update && !zero_sample) nxt_state = ST_DIV_OFF;
            ST_DIV_OFF: if (div_done) nxt_state = ST_DIV_ON;
            ST_DIV_ON:  if (div_done) nxt_state = ST_SPLIT;
            ST_SPLIT:   nxt_state = ST_APPLY;
            ST_APPLY:   if (apply_ok) nxt_state = ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= ST_IDLE;
            drop_used_ff <= 10'h000;
            idx_used_ff  <= 4'h0;
            cath_new_ff  <= 1'b0;
            off_cnt_ff   <= 16'h0000;
            on_max_ff    <= 16'h0000;
            shadow_ff    <= '0;
            load_ff      <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            load_ff  <= 1'b0;
            if (cath_take)
                cath_new_ff <= 1'b1;
            else if (state_ff == ST_IDLE && nxt_state == ST_DIV_OFF)
                cath_new_ff <= 1'b0;
            if (state_ff == ST_IDLE && nxt_state == ST_DIV_OFF) begin
                drop_used_ff <= drop_ff;
                idx_used_ff  <= idx_clamped;
            end
            if (state_ff == ST_DIV_OFF && div_done)
                off_cnt_ff <= sat16(div_q);
            if (state_ff == ST_DIV_ON && div_done)
                on_max_ff <= sat16(div_q);
            if (state_ff == ST_APPLY && apply_ok) begin
                shadow_ff.off_time_count      <= off_cnt_ff;
                shadow_ff.fault_zone_count    <= fault_cnt;
                shadow_ff.current_limit_count <= on_max_ff - fault_cnt;
                shadow_ff.dac_code            <= dac_code;
                load_ff                       <= 1'b1;
            end
        end
    end
    assign shadow      = shadow_ff;
    assign shadow_load = load_ff;
    assign calc_busy   = state_ff != ST_IDLE;
    // ==================================================
    // Checks.

    property p_load_gated;
        @(posedge mclk) disable iff (!rst_n)
        shadow_load |-> $past(hold_ff || off_ff);
    endproperty
    a_load_gated: assert property (p_load_gated)
        else $error("load outside hold or off state");

    property p_split_sum;
        @(posedge mclk) disable iff (!rst_n)
        shadow_load |-> shadow.fault_zone_count + shadow.current_limit_count == $past(on_max_ff);
    endproperty
    a_split_sum: assert property (p_split_sum)
        else $error("on-time split does not sum");

    property p_dac_map;
        @(posedge mclk) disable iff (!rst_n)
        shadow_load |-> shadow.dac_code == 8'h03 + {4'h0, $past(idx_clamped, 1)};
    endproperty
    a_dac_map: assert property (p_dac_map)
        else $error("dac code mapping wrong");

    property p_zero_skip;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && zero_sample && ce) |=> state_ff == ST_IDLE;
    endproperty
    a_zero_skip: assert property (p_zero_skip)
        else $error("division started on zero sample");

    property p_no_spurious;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && !need_update && ce) |=> state_ff == ST_IDLE;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("update without cause");

    property p_cath_delay;
        @(posedge mclk) disable iff (!rst_n)
        (dim_rise && ce) |-> !cath_take;
    endproperty
    a_cath_delay: assert property (p_cath_delay)
        else $error("cathode taken too early");

    property p_off_div;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_DIV_OFF && div_done && ce && div_q <= 32'h0000ffff)
            |=> off_cnt_ff == $past(div_q[15:0]);
    endproperty
    a_off_div: assert property (p_off_div)
        else $error("off count not stored");

    property p_div_bound;
        @(posedge mclk) disable iff (!rst_n)
        $rose(state_ff == ST_DIV_OFF) |-> ##[1:80] state_ff == ST_SPLIT || !ce;
    endproperty
    a_div_bound: assert property (p_div_bound)
        else $error("divisions too slow");

    property p_on_div;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_DIV_ON && div_done && ce && div_q <= 32'h0000ffff)
            |=> on_max_ff == $past(div_q[15:0]);
    endproperty
    a_on_div: assert property (p_on_div)
        else $error("on-time count not stored");

    property p_load_pulse;
        @(posedge mclk) disable iff (!rst_n)
        (shadow_load && ce) |=> !shadow_load;
    endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("load strobe longer than one cycle");

    property p_shadow_stable;
        @(posedge mclk) disable iff (!rst_n)
        !shadow_load |-> $stable(shadow);
    endproperty
    a_shadow_stable: assert property (p_shadow_stable)
        else $error("shadow changed without load");

    property p_fault_le;
        @(posedge mclk) disable iff (!rst_n)
        shadow_load |-> shadow.fault_zone_count <= shadow.current_limit_count;
    endproperty
    a_fault_le: assert property (p_fault_le)
        else $error("fault zone larger than its share");

    property p_cath_hold;
        @(posedge mclk) disable iff (!rst_n)
        (!cath_take && ce) |=> $stable(cath_ff);
    endproperty
    a_cath_hold: assert property (p_cath_hold)
        else $error("cathode sample changed outside capture");

    property p_div_done_idle;
        @(posedge mclk) disable iff (!rst_n)
        div_done |-> !div_busy;
    endproperty
    a_div_done_idle: assert property (p_div_done_idle)
        else $error("divider done while busy");

    property p_used_snap;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && nxt_state == ST_DIV_OFF && ce)
            |=> drop_used_ff == $past(drop_ff);
    endproperty
    a_used_snap: assert property (p_used_snap)
        else $error("used drop sample not recorded");

    property p_apply_wait;
        @(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_APPLY && !apply_ok && ce) |=> state_ff == ST_APPLY && !shadow_load;
    endproperty
    a_apply_wait: assert property (p_apply_wait)
        else $error("apply did not wait for a safe state");
endmodule : fot_param_calc
`default_nettype wire

// ---- inc/fot_consts.svh ----
// Behaviour
// - Off-time is a 16-bit count at 96 MHz.
// - Count equals off-time times state-machine clock.
// - Drop sample is supply minus cathode sample.
// - Samples are 10-bit, 1.25 V full scale.
// - Off-time count is constant over drop sample.
// - Recompute when drop sample, index or cathode sample changes.
// - Max on-time is 2.4 constant over cathode.
// - Max on-time splits into two consecutive timers.
// - Three divisions plus load within 200 us.
// - Index 0..10 maps to DAC 0x03..0x0d.
// - Per-index constants held in lookup table.
// - Cathode sampled 100 us into dimming on-period.
// - Average 90 percent of peak, ripple 10 percent.
// - On-time gets 20 percent margin, then doubled.
// - Off-time count loads the off-state register.
// - Comparator ends on-time; count is upper bound.
// - Fault zone lasts 33 percent of on-time.
// - Apply values only in hold or off-state.
`ifndef FOT_CONSTS_SVH
`define FOT_CONSTS_SVH
`define MCLK_HZ          250000000
`define SM_CLK_HZ        96000000
`define ADC_BITS         10
`define ADC_STEPS        1024
`define ADC_FS_MV        1250
`define INDEX_MAX        4'ha
`define DAC_BASE         8'h03
`define CATH_DELAY_US    100
`define CATH_DELAY_CYC   ((`CATH_DELAY_US * (`MCLK_HZ / 1000000)))
`define UPDATE_LIMIT_US  200
`define UPDATE_LIMIT_CYC ((`UPDATE_LIMIT_US * (`MCLK_HZ / 1000000)))
`define ON_MAX_NUM       12
`define ON_MAX_DEN       5
`define FAULT_PCT        33
`define TIMER_BITS       16
`define TIMER_MAX        16'hffff
`endif

// ---- inc/fot_pkg.sv ----
package fot_pkg;
    typedef struct packed {
        logic [15:0] off_time_count;
        logic [15:0] fault_zone_count;
        logic [15:0] current_limit_count;
        logic [7:0]  dac_code;
    } shadow_s;
    typedef enum logic [1:0] {DIV_OFF, DIV_FAULT, DIV_LIMIT} div_sel_e;
endpackage : fot_pkg

// ---- tb/fot_stage_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// State machine status model
module fot_stage_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic allow,
    input  wire logic dim,
    output logic      sm_in_hold,
    output logic      sm_in_off_state
);
    logic [3:0] ph_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff <= 4'h0;
        end else begin
            ph_ff <= ph_ff + 4'h1;
        end
    end

    // Hold while dimming is off, off-state half of each switching period.
    assign sm_in_hold      = allow & ~dim;
    assign sm_in_off_state = allow & dim & ph_ff[3];
endmodule : fot_stage_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fot_consts.svh"
// ====================================================================
// Testbench
module tb_top;
    import fot_pkg::*;
    localparam int CDLY = 20;
    logic       mclk, rst_n, ce, sample_valid, dimming_on, allow;
    logic       sm_in_hold, sm_in_off_state, shadow_load, calc_busy;
    logic [3:0] idx;
    logic [9:0] sup, cath;
    shadow_s    shadow;
    int         bad_count, checks_done, seed, m_idx, m_cath, m_drop;
    int         s_cur, c_cur, s, c, d;
    shadow_s    e_keep;
    int         k_tab[11] = '{45407, 60543, 75678, 90814, 105949, 121085,
                              136221, 151356, 166492, 181628, 196763};
    int         ilist[12] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 3, 15};

    fot_param_calc #(.CATH_DELAY_CYC(CDLY)) fot_param_calc_i (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .current_index_command(idx),
        .led_supply_voltage(sup), .led_cathode_voltage(cath),
        .sample_valid(sample_valid), .dimming_on(dimming_on),
        .sm_in_hold(sm_in_hold), .sm_in_off_state(sm_in_off_state),
        .shadow(shadow), .shadow_load(shadow_load), .calc_busy(calc_busy));

    fot_stage_model fot_stage_model_i (
        .mclk(mclk), .rst_n(rst_n), .allow(allow), .dim(dimming_on),
        .sm_in_hold(sm_in_hold), .sm_in_off_state(sm_in_off_state));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic shadow_s model_sh();
        longint  on_max;
        shadow_s e;
        on_max = (longint'(k_tab[m_idx]) * 12 / 5) / m_cath;
        e.off_time_count      = 16'(k_tab[m_idx] / m_drop);
        e.fault_zone_count    = 16'(on_max * 33 / 100);
        e.current_limit_count = 16'(on_max - on_max * 33 / 100);
        e.dac_code            = 8'(3 + m_idx);
        return e;
    endfunction : model_sh

    task automatic cmp_sh(input shadow_s e);
        checks_done++;
        if (shadow !== e) begin
            bad_count++;
            $display("FAIL %0t shadow %h expected %h", $time, shadow, e);
        end
    endtask : cmp_sh

    task automatic cmp_bit(input logic a, input logic e, input string m);
        checks_done++;
        if (a !== e) begin
            bad_count++;
            $display("FAIL %0t %0s", $time, m);
        end
    endtask : cmp_bit

    task automatic drv(input int i, input int sv, input int cv);
        @(posedge mclk);
        idx   <= 4'(i);
        sup   <= 10'(sv);
        cath  <= 10'(cv);
        m_idx  = (i > 10) ? 10 : i;
        m_drop = sv - cv;
        s_cur  = sv;
        c_cur  = cv;
    endtask : drv

    task automatic dim(input int cv);
        @(posedge mclk);
        dimming_on <= 1'b0;
        repeat (2) @(posedge mclk);
        dimming_on <= 1'b1;
        m_cath = cv;
    endtask : dim

    task automatic wait_load(input logic exp_load, input int lim, input string t);
        int   n;
        logic got;
        n   = 0;
        got = 1'b0;
        while (n < lim && !got) begin
            @(negedge mclk);
            n++;
            got = (shadow_load === 1'b1);
        end
        cmp_bit(got, exp_load, "load presence");
        if (got && exp_load) begin
            cmp_sh(model_sh());
            cmp_bit(n < `UPDATE_LIMIT_CYC, 1'b1, "update latency");
            cmp_bit(calc_busy, 1'b0, "busy after load");
        end
        $display("test %0s done", t);
    endtask : wait_load

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        seed = 36;
        {rst_n, ce, sample_valid, dimming_on, allow, idx, sup, cath} = '0;
        repeat (8) @(posedge mclk);
        rst_n        <= 1'b1;
        ce           <= 1'b1;
        sample_valid <= 1'b1;
        allow        <= 1'b1;
        @(negedge mclk);
        cmp_sh('0);
        cmp_bit(shadow_load, 1'b0, "reset load");
        cmp_bit(calc_busy, 1'b0, "reset busy");
        $display("test reset done");
        drv(0, 400, 200);
        dim(200);
        wait_load(1'b1, 1000, "first capture");
        foreach (ilist[j]) begin
            drv(ilist[j], s_cur, c_cur);
            wait_load(1'b1, 1000, "index step");
        end
        repeat (6) begin
            s = c_cur + 4 + ($random(seed) & 511);
            if (s == s_cur) s++;
            drv(int'(idx), s, c_cur);
            wait_load(1'b1, 1000, "drop change");
        end
        repeat (4) begin
            c = 16 + ($random(seed) & 255);
            if (c == c_cur) c++;
            d = s_cur - c_cur;
            drv(int'(idx), c + d, c);
            dim(c);
            wait_load(1'b1, 1000, "cathode change");
        end
        s = s_cur;
        e_keep = model_sh();
        drv(int'(idx), c_cur, c_cur);
        wait_load(1'b0, 150, "zero drop");
        cmp_sh(e_keep);
        drv(int'(idx), s + 1, c_cur);
        wait_load(1'b1, 1000, "drop restored");
        @(posedge mclk);
        allow <= 1'b0;
        drv(int'(idx), s + 3, c_cur);
        wait_load(1'b0, 150, "apply blocked");
        cmp_bit(calc_busy, 1'b1, "busy while held");
        @(posedge mclk);
        allow <= 1'b1;
        wait_load(1'b1, 1000, "apply released");
        drv(int'(idx), s + 5, c_cur);
        ce <= 1'b0;
        repeat (100) @(posedge mclk);
        @(negedge mclk);
        cmp_bit(shadow_load | calc_busy, 1'b0, "frozen by enable");
        $display("test enable hold done");
        @(posedge mclk);
        ce <= 1'b1;
        wait_load(1'b1, 1000, "enable resumed");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
